// ### rtl/rpr_pkg.sv
// Package: read parameter register constants and types
package rpr_pkg;
  // Command opcodes
  localparam logic [7:0] RPR_CMD_SET_PERSISTENT = 8'h65;
  localparam logic [7:0] RPR_CMD_SET_VOLATILE_A = 8'hc0;
  localparam logic [7:0] RPR_CMD_SET_VOLATILE_B = 8'h63;
  // Reset values
  localparam logic [7:0] RPR_RESET_VALUE        = 8'h00;
  // Field positions
  localparam int RPR_PIN_SEL_POS   = 7;
  localparam int RPR_DUMMY_HI_POS  = 6;
  localparam int RPR_DUMMY_LO_POS  = 3;
  localparam int RPR_WRAP_EN_POS   = 2;
  localparam int RPR_BURST_HI_POS  = 1;
  localparam int RPR_BURST_LO_POS  = 0;
  // Default dummy counts per read class
  localparam logic [3:0] RPR_DUMMY_DEF_SINGLE  = 4'h8;
  localparam logic [3:0] RPR_DUMMY_DEF_QUAD_IO = 4'h6;
  localparam logic [3:0] RPR_DUMMY_DEF_DUAL_IO = 4'h4;
  // Burst lengths in bytes
  localparam logic [6:0] RPR_BURST_8  = 7'h08;
  localparam logic [6:0] RPR_BURST_16 = 7'h10;
  localparam logic [6:0] RPR_BURST_32 = 7'h20;
  localparam logic [6:0] RPR_BURST_64 = 7'h40;

  // Read command classes for default dummy choice
  typedef enum logic [1:0] {
    RPR_RD_SINGLE  = 2'b00,
    RPR_RD_OUTPUT  = 2'b01,
    RPR_RD_QUAD_IO = 2'b10,
    RPR_RD_DUAL_IO = 2'b11
  } rpr_rd_class_t;

  // Load sequencer states
  typedef enum logic [1:0] {
    RPR_ST_LOAD = 2'b00,
    RPR_ST_RUN  = 2'b01
  } rpr_state_t;
endpackage : rpr_pkg

// ### rtl/rpr_decode.sv
// Decode of working read parameters into pin, dummy and wrap controls
`timescale 1ns/1ps
`default_nettype none
module rpr_decode
  import rpr_pkg::*;
(
  input  wire logic [7:0]    params_in,
  input  wire logic          quad_enable_in,
  input  wire logic          four_lane_command_mode_in,
  input  wire logic          reset_pin_disabled_in,
  input  wire rpr_rd_class_t rd_class_in,
  output logic               pin_is_reset_out,
  output logic               pin_is_data_line_3_out,
  output logic [3:0]         dummy_cycles_out,
  output logic               wrap_enable_out,
  output logic [6:0]         burst_bytes_out
);
  logic [3:0] dummy_field;

  // Shared pin role
  always_comb begin
    pin_is_data_line_3_out = quad_enable_in | four_lane_command_mode_in; // RULE_04 RULE_13
    // Enabled dedicated reset pin forces pause role
    pin_is_reset_out = !pin_is_data_line_3_out && reset_pin_disabled_in
                       && params_in[RPR_PIN_SEL_POS]; // RULE_03 RULE_05
  end

  // Dummy count with per-class defaults
  always_comb begin
    dummy_field = params_in[RPR_DUMMY_HI_POS:RPR_DUMMY_LO_POS]; // RULE_06
    if (dummy_field != 4'h0) begin
      dummy_cycles_out = dummy_field;
    end else begin
      case (rd_class_in) // RULE_07
        RPR_RD_SINGLE:  dummy_cycles_out = four_lane_command_mode_in ? RPR_DUMMY_DEF_QUAD_IO
                                                                     : RPR_DUMMY_DEF_SINGLE;
        RPR_RD_OUTPUT:  dummy_cycles_out = RPR_DUMMY_DEF_SINGLE;
        RPR_RD_QUAD_IO: dummy_cycles_out = RPR_DUMMY_DEF_QUAD_IO;
        RPR_RD_DUAL_IO: dummy_cycles_out = RPR_DUMMY_DEF_DUAL_IO;
        default:        dummy_cycles_out = RPR_DUMMY_DEF_SINGLE;
      endcase
    end
  end

  // Wrap control
  always_comb begin
    wrap_enable_out = params_in[RPR_WRAP_EN_POS]; // RULE_09
    case (params_in[RPR_BURST_HI_POS:RPR_BURST_LO_POS]) // RULE_08
      2'b00:   burst_bytes_out = RPR_BURST_8;
      2'b01:   burst_bytes_out = RPR_BURST_16;
      2'b10:   burst_bytes_out = RPR_BURST_32;
      2'b11:   burst_bytes_out = RPR_BURST_64;
      default: burst_bytes_out = RPR_BURST_8;
    endcase
  end
endmodule : rpr_decode
`default_nettype wire

// ### rtl/rpr_read_params.sv
// Read parameter register: persistent and working copies with decode
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01 - Keep persistent and working register copies
// RULE_02 - Power-up loads working copy from persistent
// RULE_03 - Select bit picks pause or reset pin
// RULE_04 - Quad or four-lane mode ignores select bit
// RULE_05 - Enabled dedicated reset pin forces pause role
// RULE_06 - Field 6:3 nonzero sets dummy count
// RULE_07 - Zero field uses per-command default dummies
// RULE_08 - Bits 1:0 choose 8/16/32/64 byte burst
// RULE_09 - Bit 2 enables wrap within burst
// RULE_10 - 65h writes persistent, C0h/63h write working
// RULE_11 - All bits reset to zero
// RULE_12 - Host limits clock per dummy count
// RULE_13 - Quad enable turns pins into data lines
// RULE_14 - Working copy governs; persistent waits power-up
module rpr_read_params
  import rpr_pkg::*;
(
  input  wire logic          ref_clk_in,
  input  wire logic          nrst_in,
  input  wire logic          cmd_valid_in,
  input  wire logic [7:0]    cmd_opcode_in,
  input  wire logic [7:0]    cmd_data_in,
  input  wire logic          quad_enable_in,
  input  wire logic          four_lane_command_mode_in,
  input  wire logic          reset_pin_disabled_in,
  input  wire rpr_rd_class_t rd_class_in,
  output logic [7:0]         persistent_out,
  output logic [7:0]         working_out,
  output logic               ready_out,
  output logic               pin_is_reset_out,
  output logic               pin_is_data_line_3_out,
  output logic [3:0]         dummy_cycles_out,
  output logic               wrap_enable_out,
  output logic [6:0]         burst_bytes_out
);
  logic       rst_s1_q;
  logic       rst_s2_q;
  logic       rst_n;
  rpr_state_t state_q, state_d;
  logic       ready_q, ready_d;
  logic [7:0] persist_q, persist_d;
  logic [7:0] work_q, work_d;
  logic       pin_reset_q, pin_dl3_q, wrap_q;
  logic [3:0] dummy_q;
  logic [6:0] burst_q;
  logic       pin_reset_c, pin_dl3_c, wrap_c;
  logic [3:0] dummy_c;
  logic [6:0] burst_c;

  // Opcode match used by both the write path and checks
  function automatic logic is_volatile_set(input logic [7:0] op);
    is_volatile_set = (op == RPR_CMD_SET_VOLATILE_A) || (op == RPR_CMD_SET_VOLATILE_B);
  endfunction : is_volatile_set

  // Reset release synchroniser
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // Next values for copies and load sequencer
  always_comb begin
    state_d   = state_q;
    persist_d = persist_q;
    work_d    = work_q;
    case (state_q)
      RPR_ST_LOAD: begin
        // Persistent copy is cleared by the same reset, so this loads zeros into working copy
        work_d  = persist_q; // RULE_02
        state_d = RPR_ST_RUN;
      end
      RPR_ST_RUN: begin
        if (cmd_valid_in) begin
          // Whole byte written at once
          if (cmd_opcode_in == RPR_CMD_SET_PERSISTENT) begin
            persist_d = cmd_data_in; // RULE_10 RULE_14
          end else if (is_volatile_set(cmd_opcode_in)) begin
            work_d = cmd_data_in; // RULE_10
          end
        end
      end
      default: state_d = RPR_ST_LOAD;
    endcase
    // Ready flag registered so the port comes from a flop
    ready_d = (state_d == RPR_ST_RUN);
  end

  // The one reset stands for power-up, so it clears the persistent copy too;
  // a real persistent copy would outlive it, so loads only ever move zeros here
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= RPR_ST_LOAD;
      ready_q   <= 1'b0;
      persist_q <= RPR_RESET_VALUE; // RULE_11 RULE_01
      work_q    <= RPR_RESET_VALUE; // RULE_11 RULE_01
    end else begin
      state_q   <= state_d;
      ready_q   <= ready_d;
      persist_q <= persist_d;
      work_q    <= work_d;
    end
  end

  // Decode of working copy, host keeps clock in range (RULE_12 is theirs)
  rpr_decode u_decode (
    .params_in                 (work_q), // RULE_14
    .quad_enable_in            (quad_enable_in),
    .four_lane_command_mode_in (four_lane_command_mode_in),
    .reset_pin_disabled_in     (reset_pin_disabled_in),
    .rd_class_in               (rd_class_in),
    .pin_is_reset_out          (pin_reset_c),
    .pin_is_data_line_3_out    (pin_dl3_c),
    .dummy_cycles_out          (dummy_c),
    .wrap_enable_out           (wrap_c),
    .burst_bytes_out           (burst_c)
  );

  // Output registers, one cycle behind the working copy
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_reset_q <= 1'b0;
      pin_dl3_q   <= 1'b0;
      wrap_q      <= 1'b0;
      dummy_q     <= 4'h0;
      burst_q     <= 7'h00;
    end else begin
      pin_reset_q <= pin_reset_c;
      pin_dl3_q   <= pin_dl3_c;
      wrap_q      <= wrap_c;
      dummy_q     <= dummy_c;
      burst_q     <= burst_c;
    end
  end

  assign persistent_out         = persist_q;
  assign working_out            = work_q;
  assign ready_out              = ready_q;
  assign pin_is_reset_out       = pin_reset_q;
  assign pin_is_data_line_3_out = pin_dl3_q;
  assign dummy_cycles_out       = dummy_q;
  assign wrap_enable_out        = wrap_q;
  assign burst_bytes_out        = burst_q;

  // Write sequences
  sequence s_vol_write;
    cmd_valid_in && ready_out && is_volatile_set(cmd_opcode_in);
  endsequence
  sequence s_per_write;
    cmd_valid_in && ready_out && (cmd_opcode_in == RPR_CMD_SET_PERSISTENT);
  endsequence

  a_vol_write_lands: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_10
    s_vol_write |=> (work_q == $past(cmd_data_in)))
    else $error("working copy not written");
  a_per_write_lands: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_10
    s_per_write |=> (persist_q == $past(cmd_data_in)))
    else $error("persistent copy not written");
  a_per_no_work: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_14
    s_per_write |=> $stable(work_q))
    else $error("persistent write disturbed working copy");
  a_powerup_load: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_02
    (state_q == RPR_ST_LOAD) |=> (work_q == $past(persist_q)) && ready_out)
    else $error("power-up load failed");
  a_ready_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_02
    ready_out |=> ready_out)
    else $error("ready dropped without reset");
  // Commands seen before ready, or with a foreign opcode, must leave no trace
  a_refuse_busy: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_10
    (cmd_valid_in && !ready_out) |=> $stable(persist_q))
    else $error("command taken before ready");
  a_unknown_op: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_10
    (cmd_valid_in && ready_out && !is_volatile_set(cmd_opcode_in) && (cmd_opcode_in != RPR_CMD_SET_PERSISTENT))
    |=> $stable(work_q) && $stable(persist_q))
    else $error("unknown opcode changed a copy");
  a_dl3_pin: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_04
    (quad_enable_in || four_lane_command_mode_in) |=> pin_dl3_q && !pin_reset_q)
    else $error("shared pin not data line");
  a_dl3_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_13
    (!quad_enable_in && !four_lane_command_mode_in) |=> !pin_dl3_q)
    else $error("shared pin stuck as data line");
  a_pin_select: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_03
    (!quad_enable_in && !four_lane_command_mode_in && reset_pin_disabled_in)
    |=> (pin_reset_q == $past(work_q[RPR_PIN_SEL_POS])))
    else $error("pin role mismatch");
  a_dedicated_rst: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_05
    !reset_pin_disabled_in |=> !pin_reset_q)
    else $error("pause role not forced");
  a_dummy_field: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_06
    (work_q[6:3] != 4'h0) |=> (dummy_q == $past(work_q[6:3])))
    else $error("dummy count mismatch");

  // Default dummy counts per read class
  a_dummy_dual: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_07
    (work_q[6:3] == 4'h0) && (rd_class_in == RPR_RD_DUAL_IO) |=> (dummy_q == 4'h4))
    else $error("dual io default wrong");
  a_dummy_quad_io: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_07
    (work_q[6:3] == 4'h0) && (rd_class_in == RPR_RD_QUAD_IO) |=> (dummy_q == RPR_DUMMY_DEF_QUAD_IO))
    else $error("quad io default wrong");
  a_dummy_output: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_07
    (work_q[6:3] == 4'h0) && (rd_class_in == RPR_RD_OUTPUT) |=> (dummy_q == RPR_DUMMY_DEF_SINGLE))
    else $error("output read default wrong");
  a_dummy_single: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_07
    (work_q[6:3] == 4'h0) && (rd_class_in == RPR_RD_SINGLE) && !four_lane_command_mode_in
    |=> (dummy_q == RPR_DUMMY_DEF_SINGLE))
    else $error("single read default wrong");
  a_dummy_4lane: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_07
    (work_q[6:3] == 4'h0) && (rd_class_in == RPR_RD_SINGLE) && four_lane_command_mode_in
    |=> (dummy_q == RPR_DUMMY_DEF_QUAD_IO))
    else $error("four-lane read default wrong");
  a_burst_len: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_08
    1'b1 |=> (burst_q == (7'h08 << $past(work_q[1:0]))))
    else $error("burst length wrong");
  a_wrap_bit: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // RULE_09
    1'b1 |=> (wrap_q == $past(work_q[2])))
    else $error("wrap enable wrong");
endmodule : rpr_read_params
`default_nettype wire

// ### verif/rpr_host_model.sv
// Host controller model that issues set-parameter commands
`timescale 1ns/1ps
`default_nettype none
module rpr_host_model (
  input  wire logic       clk_in,
  output logic            cmd_valid_out,
  output logic [7:0]      cmd_opcode_out,
  output logic [7:0]      cmd_data_out
);
  // Idle bus at time zero
  initial begin
    cmd_valid_out  = 1'b0;
    cmd_opcode_out = 8'h00;
    cmd_data_out   = 8'h00;
  end

  // Whole byte per command, strobe for one core cycle only
  // Commands never run faster than the core clock allows
  task automatic send(input logic [7:0] op, input logic [7:0] val);
    @(posedge clk_in);
    cmd_valid_out  <= 1'b1;
    cmd_opcode_out <= op;
    cmd_data_out   <= val;
    @(posedge clk_in);
    // Inverted leftovers so a stale byte is never read as a fresh one
    cmd_valid_out  <= 1'b0;
    cmd_opcode_out <= ~op;
    cmd_data_out   <= ~val;
  endtask : send
endmodule : rpr_host_model
`default_nettype wire

// ### verif/read_parameter_register_tb.sv
// Self-checking bench for the read parameter register
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module read_parameter_register_tb
  import rpr_pkg::*;
;
  logic          ref_clk_in = 1'b0;
  logic          nrst_in;
  logic          cmd_valid;
  logic [7:0]    cmd_opcode;
  logic [7:0]    cmd_data;
  logic          quad_mode;
  logic          fl;
  logic          rpd;
  rpr_rd_class_t cls;
  logic [7:0]    persistent_out;
  logic [7:0]    working_out;
  logic          ready_out;
  logic          pin_is_reset_out;
  logic          pin_is_data_line_3_out;
  logic [3:0]    dummy_cycles_out;
  logic          wrap_enable_out;
  logic [6:0]    burst_bytes_out;
  int            err_total = 0;
  int            tests_run = 0;
  int            cyc       = 0;

  always #4 ref_clk_in = ~ref_clk_in;

  rpr_host_model i_host (.clk_in(ref_clk_in), .cmd_valid_out(cmd_valid), .cmd_opcode_out(cmd_opcode),
                         .cmd_data_out(cmd_data));

  rpr_read_params i_dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .cmd_valid_in(cmd_valid),
    .cmd_opcode_in(cmd_opcode), .cmd_data_in(cmd_data), .quad_enable_in(quad_mode), .four_lane_command_mode_in(fl),
    .reset_pin_disabled_in(rpd), .rd_class_in(cls), .persistent_out(persistent_out),
    .working_out(working_out), .ready_out(ready_out), .pin_is_reset_out(pin_is_reset_out),
    .pin_is_data_line_3_out(pin_is_data_line_3_out), .dummy_cycles_out(dummy_cycles_out),
    .wrap_enable_out(wrap_enable_out), .burst_bytes_out(burst_bytes_out));

  // Verdict and counts, reached from the main flow or the watchdog
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // Watchdog well above the expected 150 or so cycles
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_sim();
    end
  end

  // Reset held three cycles
  task automatic do_reset();
    nrst_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
  endtask : do_reset

  task automatic wait_ready();
    int n;
    n = 0;
    #1;
    while (ready_out !== 1'b1 && n < 20) begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    `CHK("ready", 1'b1, ready_out)
  endtask : wait_ready

  // Command then two cycles for the decoded outputs to land
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    i_host.send(op, d);
    repeat (2) @(posedge ref_clk_in);
    #1;
  endtask : wr

  // Mode pins follow with one cycle of delay, two allowed here
  task automatic set_mode(input logic q, input logic f, input logic r, input logic [1:0] c);
    @(posedge ref_clk_in);
    quad_mode <= q;
    fl  <= f;
    rpd <= r;
    cls <= rpr_rd_class_t'(c);
    repeat (2) @(posedge ref_clk_in);
    #1;
  endtask : set_mode

  initial begin
    int         i;
    logic [7:0] d;
    logic [3:0] dtab [4];
    dtab = '{4'h8, 4'h8, 4'h6, 4'h4};
    nrst_in = 1'b0;
    quad_mode = 1'b0;
    fl = 1'b0;
    rpd = 1'b1;
    cls = RPR_RD_SINGLE;
    do_reset();
    wait_ready();
    `CHK("pers_rst", 8'h00, persistent_out)
    `CHK("work_rst", 8'h00, working_out)
    `CHK("wrap_rst", 1'b0, wrap_enable_out)
    // Pin role across every quad, four-lane and dedicated-reset combination
    wr(RPR_CMD_SET_VOLATILE_A, 8'h80);
    `CHK("pers_kept", 8'h00, persistent_out)
    for (i = 0; i < 8; i++) begin
      set_mode(i[0], i[1], i[2], 2'b00);
      `CHK("pin_rst", !i[0] && !i[1] && i[2], pin_is_reset_out)
      `CHK("pin_dl3", i[0] || i[1], pin_is_data_line_3_out)
    end
    // Every dummy field, burst code and wrap setting through both working opcodes
    set_mode(1'b0, 1'b0, 1'b1, 2'b00);
    for (i = 0; i < 16; i++) begin
      d = {i[1], i[3:0], i[0], i[1:0]};
      wr(i[0] ? RPR_CMD_SET_VOLATILE_A : RPR_CMD_SET_VOLATILE_B, d);
      `CHK("work_wr", d, working_out)
      `CHK("dummy", (i == 0) ? 4'h8 : i[3:0], dummy_cycles_out)
      `CHK("burst", 7'h08 << i[1:0], burst_bytes_out)
      `CHK("wrap", i[0], wrap_enable_out)
      `CHK("sel_bit", i[1], pin_is_reset_out)
    end
    // Default dummy count of each read class
    wr(RPR_CMD_SET_VOLATILE_B, 8'h00);
    for (i = 0; i < 4; i++) begin
      set_mode(1'b0, 1'b0, 1'b1, i[1:0]);
      `CHK("dummy_def", dtab[i], dummy_cycles_out)
    end
    set_mode(1'b0, 1'b1, 1'b1, 2'b00);
    `CHK("dummy_4lane", 4'h6, dummy_cycles_out)
    // Persistent write leaves the working copy alone; unknown opcode ignored
    wr(RPR_CMD_SET_PERSISTENT, 8'h5a);
    `CHK("pers_wr", 8'h5a, persistent_out)
    `CHK("work_hold", 8'h00, working_out)
    wr(8'h66, 8'hff);
    `CHK("pers_unk", 8'h5a, persistent_out)
    `CHK("work_unk", 8'h00, working_out)
    // Second reset clears both copies; a write in the load cycle is dropped
    @(posedge ref_clk_in);
    do_reset();
    @(posedge ref_clk_in);
    i_host.send(RPR_CMD_SET_PERSISTENT, 8'hff);
    wait_ready();
    `CHK("load_work", RPR_RESET_VALUE, working_out)
    `CHK("drop_cmd", RPR_RESET_VALUE, persistent_out)
    end_sim();
  end
endmodule : read_parameter_register_tb
`undef CHK
`default_nettype wire
